/* pkg/pdci_pkg.sv */
package pdci_pkg;

    // bus geometry: register index sits at byte address bits [7:2]
    localparam int ADDR_W = 8;
    localparam int IDX_LSB = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register indices (byte address is four times the index)
    localparam logic [5:0] IDX_INPUT_SEL = 6'h0d;
    localparam logic [5:0] IDX_PERIOD = 6'h0e;
    localparam logic [5:0] IDX_IIR0_HI_LO = 6'h0f;
    localparam logic [5:0] IDX_IIR0_HI_HI = 6'h10;
    localparam logic [5:0] IDX_IIR0_LO_LO = 6'h11;
    localparam logic [5:0] IDX_IIR0_LO_HI = 6'h12;
    localparam logic [5:0] IDX_IIR0_FMT = 6'h13;
    localparam logic [5:0] IDX_IIR1_HI_LO = 6'h16;
    localparam logic [5:0] IDX_IIR1_HI_HI = 6'h17;
    localparam logic [5:0] IDX_IIR1_LO_LO = 6'h18;
    localparam logic [5:0] IDX_IIR1_LO_HI = 6'h19;
    localparam logic [5:0] IDX_IIR1_FMT = 6'h1a;
    localparam logic [5:0] IDX_HOLD_LO = 6'h1d;
    localparam logic [5:0] IDX_HOLD_HI = 6'h1e;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h28;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h29;
    localparam logic [5:0] IDX_FLAG_STATE = 6'h2a;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] RST_EXP = 4'h0;
    localparam logic [1:0] RST_IRQ = 2'h0;

    // field positions and widths
    localparam int EXP_W = 4;
    localparam int THR_W = 16;
    localparam int FRAC_BITS = 14;
    localparam logic signed [15:0] FULL_POS = 16'sh4000;
    localparam logic signed [15:0] FULL_NEG = 16'shc000;
    localparam int PERIOD_MAX = 32768;

    // crossing rate is the sample clock divided by eight
    localparam int TICK_DIV = 8;
    localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);

    // comparator outputs of the block peak detector
    typedef struct packed {
        logic high_pair_upper_cmp;
        logic high_pair_lower_cmp;
        logic low_pair_upper_cmp;
        logic low_pair_lower_cmp;
    } pdci_cmp_t;

    // per-filter comparator setup
    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
        logic two_bit;
    } pdci_thr_t;

endpackage

/* src/pdci_channel.sv */
`timescale 1ns/1ps
module pdci_channel (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // filter input at the crossing rate
    input wire logic tick,
    input wire logic signed [1:0] x,
    input wire logic [3:0] exponent,
    // comparator setup
    input wire pdci_pkg::pdci_thr_t cfg,
    input wire logic [15:0] hold_count,
    // results
    output logic signed [15:0] y,
    output logic peak,
    output logic [1:0] alarm
);
    logic signed [17:0] target;
    logic signed [17:0] diff;
    logic signed [17:0] step;
    logic signed [17:0] next_y;
    logic [15:0] hold_cnt;
    logic below_lo;
    logic above_hi;

    // target is x in 2.14, so +1 maps to 4000h and -1 to c000h
    assign target = {{2{x[1]}}, x, 14'h0000};
    assign diff = target - {{2{y[15]}}, y};
    assign step = diff >>> exponent;
    assign next_y = {{2{y[15]}}, y} + step;
    assign below_lo = y < $signed(cfg.low);
    assign above_hi = y > $signed(cfg.high);

    // one-pole smoother, time constant of 2^n crossing ticks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            y <= 16'sh0000;
        end else if (tick) begin
            y <= next_y[15:0];
        end
    end

    // set on crossing high; clear only after a run below low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peak <= 1'b0;
            hold_cnt <= 16'h0000;
        end else if (tick) begin
            if (above_hi) begin
                peak <= 1'b1;
                hold_cnt <= 16'h0000;
            end else if (peak && below_lo) begin
                if (hold_cnt >= hold_count) begin
                    peak <= 1'b0;
                    hold_cnt <= 16'h0000;
                end else begin
                    hold_cnt <= hold_cnt + 16'h0001;
                end
            end else begin
                hold_cnt <= 16'h0000; // run broken, start over
            end
        end
    end

    // 1-bit format carries only the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm <= 2'h0;
        end else begin
            alarm <= cfg.two_bit ? {peak, below_lo} : {1'b0, peak};
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    fast_step_a: assert property (tick && exponent == 4'h0 |=> y == $past(target[15:0]))
        else $error("filter did not reach target at zero exponent");
    y_range_a: assert property (y >= pdci_pkg::FULL_NEG && y <= pdci_pkg::FULL_POS)
        else $error("filter output outside plus or minus one");
    peak_set_a: assert property (tick && above_hi |=> peak)
        else $error("peak flag not set above high threshold");
    peak_hold_a: assert property (peak && tick && !below_lo |=> peak)
        else $error("peak flag cleared while not below low threshold");
    fmt_one_a: assert property (!cfg.two_bit |=> alarm == {1'b0, $past(peak)})
        else $error("1-bit alarm format wrong");
    fmt_two_a: assert property (cfg.two_bit |=> alarm[1] == $past(peak))
        else $error("2-bit alarm format wrong");
    peak_clear_c: cover property (peak ##1 !peak);
endmodule // pdci_channel

/* src/pdci_top.sv */
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - with input select 0 the filter-0 input is built only from the two high-pair comparators.
// - with input select 1 the high and low pairs merge into a -1, 0, +1 filter input.
// - the crossing period is 2^N crossing ticks, N a 4-bit field, at most 32768 ticks.
// - thresholds are 16-bit signed 2.14 values, 4000h meaning every sample crossing.
// - each of the two filters has a high and a low threshold, each split over two byte registers.
// - a per-filter format bit picks a 1-bit comparator output at 0 and a 2-bit one at 1.
// - the peak flag sets when the output crosses high and clears after a full hold run below low.
module pdci_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // block peak comparator outputs, same clock
    input wire pdci_pkg::pdci_cmp_t cmp,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // alarms toward gain control and interrupt
    output logic [1:0] alarm0,
    output logic [1:0] alarm1,
    output logic irq
);
    // crossing tick divider
    logic [2:0] div_cnt;
    logic tick;

    // configuration
    logic input_sel;
    logic [3:0] exponent;
    pdci_pkg::pdci_thr_t thr0;
    pdci_pkg::pdci_thr_t thr1;
    logic [15:0] hold_count;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    // bus holding state
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb_q;
    logic do_write;
    logic [5:0] wr_idx;
    logic wr_en;
    logic wr_ok;
    logic [7:0] rd_byte;
    logic rd_ok;

    // filter inputs and results
    logic signed [1:0] x0;
    logic signed [1:0] x1;
    logic high_hit;
    logic low_hit;
    logic signed [15:0] y0;
    logic signed [15:0] y1;
    logic [1:0] peak;
    logic [1:0] peak_d;
    logic [1:0] peak_rise;
    logic [1:0] next_status;
    logic [1:0] alarm0_w;
    logic [1:0] alarm1_w;

    // one tick every eight clocks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 3'h0;
            tick <= 1'b0;
        end else begin
            div_cnt <= (div_cnt == pdci_pkg::TICK_LAST) ? 3'h0 : div_cnt + 3'h1;
            tick <= (div_cnt == pdci_pkg::TICK_LAST);
        end
    end

    // input shaping; filter 1 always sees the high pair only
    assign high_hit = cmp.high_pair_upper_cmp | cmp.high_pair_lower_cmp;
    assign low_hit = cmp.low_pair_upper_cmp | cmp.low_pair_lower_cmp;
    always_comb begin
        if (!input_sel) begin
            x0 = high_hit ? 2'sb01 : 2'sb00;
        end else if (high_hit) begin
            x0 = 2'sb01;
        end else begin
            x0 = low_hit ? 2'sb00 : 2'sb11;
        end
    end
    assign x1 = high_hit ? 2'sb01 : 2'sb00;

    // two filter channels share period and hold count
    pdci_channel u_iir0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .x(x0),
        .exponent(exponent),
        .cfg(thr0),
        .hold_count(hold_count),
        .y(y0),
        .peak(peak[0]),
        .alarm(alarm0_w)
    );
    pdci_channel u_iir1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .x(x1),
        .exponent(exponent),
        .cfg(thr1),
        .hold_count(hold_count),
        .y(y1),
        .peak(peak[1]),
        .alarm(alarm1_w)
    );

    // alarms are re-registered so the pins never see a comparator glitch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm0 <= 2'h0;
            alarm1 <= 2'h0;
        end else begin
            alarm0 <= alarm0_w;
            alarm1 <= alarm1_w;
        end
    end

    // write address channel, held until the pair is complete
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            awready <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            awready <= 1'b0;
            awaddr_q <= awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
            awready <= 1'b1;
        end else if (!aw_held) begin
            awready <= 1'b1;
        end
    end

    // write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            wready <= 1'b0;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            wready <= 1'b0;
            wdata_q <= wdata[7:0];
            wstrb_q <= wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
            wready <= 1'b1;
        end else if (!w_held) begin
            wready <= 1'b1;
        end
    end

    // commit once both halves are in and the last response is gone
    assign do_write = aw_held && w_held && !bvalid;
    assign wr_idx = awaddr_q[7:pdci_pkg::IDX_LSB];
    assign wr_en = do_write && wstrb_q;

    // decode for the response code
    always_comb begin
        case (wr_idx)
            pdci_pkg::IDX_INPUT_SEL, pdci_pkg::IDX_PERIOD,
            pdci_pkg::IDX_IIR0_HI_LO, pdci_pkg::IDX_IIR0_HI_HI,
            pdci_pkg::IDX_IIR0_LO_LO, pdci_pkg::IDX_IIR0_LO_HI,
            pdci_pkg::IDX_IIR0_FMT, pdci_pkg::IDX_IIR1_HI_LO,
            pdci_pkg::IDX_IIR1_HI_HI, pdci_pkg::IDX_IIR1_LO_LO,
            pdci_pkg::IDX_IIR1_LO_HI, pdci_pkg::IDX_IIR1_FMT,
            pdci_pkg::IDX_HOLD_LO, pdci_pkg::IDX_HOLD_HI,
            pdci_pkg::IDX_IRQ_STATUS, pdci_pkg::IDX_IRQ_MASK,
            pdci_pkg::IDX_FLAG_STATE: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= pdci_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? pdci_pkg::RESP_OKAY : pdci_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // control registers; reserved bits are dropped on write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            input_sel <= 1'b0;
            exponent <= pdci_pkg::RST_EXP;
            thr0 <= '0;
            thr1 <= '0;
            hold_count <= pdci_pkg::RST_WORD;
            irq_mask <= pdci_pkg::RST_IRQ;
        end else if (wr_en) begin
            case (wr_idx)
                pdci_pkg::IDX_INPUT_SEL: input_sel <= wdata_q[0];
                pdci_pkg::IDX_PERIOD: exponent <= wdata_q[3:0];
                pdci_pkg::IDX_IIR0_HI_LO: thr0.high[7:0] <= wdata_q;
                pdci_pkg::IDX_IIR0_HI_HI: thr0.high[15:8] <= wdata_q;
                pdci_pkg::IDX_IIR0_LO_LO: thr0.low[7:0] <= wdata_q;
                pdci_pkg::IDX_IIR0_LO_HI: thr0.low[15:8] <= wdata_q;
                pdci_pkg::IDX_IIR0_FMT: thr0.two_bit <= wdata_q[0];
                pdci_pkg::IDX_IIR1_HI_LO: thr1.high[7:0] <= wdata_q;
                pdci_pkg::IDX_IIR1_HI_HI: thr1.high[15:8] <= wdata_q;
                pdci_pkg::IDX_IIR1_LO_LO: thr1.low[7:0] <= wdata_q;
                pdci_pkg::IDX_IIR1_LO_HI: thr1.low[15:8] <= wdata_q;
                pdci_pkg::IDX_IIR1_FMT: thr1.two_bit <= wdata_q[0];
                pdci_pkg::IDX_HOLD_LO: hold_count[7:0] <= wdata_q;
                pdci_pkg::IDX_HOLD_HI: hold_count[15:8] <= wdata_q;
                pdci_pkg::IDX_IRQ_MASK: irq_mask <= wdata_q[1:0];
                default: ;
            endcase
        end
    end

    // peak rising edge is the interrupt event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peak_d <= 2'h0;
        end else begin
            peak_d <= peak;
        end
    end
    assign peak_rise = peak & ~peak_d;

    // sticky status, write one to clear; a new event beats the clear
    always_comb begin
        next_status = irq_status;
        if (wr_en && wr_idx == pdci_pkg::IDX_IRQ_STATUS) begin
            next_status = irq_status & ~wdata_q[1:0];
        end
        next_status = next_status | peak_rise;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= pdci_pkg::RST_IRQ;
        end else begin
            irq_status <= next_status;
        end
    end

    // level interrupt from the live status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & irq_mask);
        end
    end

    // read decode, reserved bits read zero
    always_comb begin
        rd_ok = 1'b1;
        case (araddr[7:pdci_pkg::IDX_LSB])
            pdci_pkg::IDX_INPUT_SEL: rd_byte = {7'h00, input_sel};
            pdci_pkg::IDX_PERIOD: rd_byte = {4'h0, exponent};
            pdci_pkg::IDX_IIR0_HI_LO: rd_byte = thr0.high[7:0];
            pdci_pkg::IDX_IIR0_HI_HI: rd_byte = thr0.high[15:8];
            pdci_pkg::IDX_IIR0_LO_LO: rd_byte = thr0.low[7:0];
            pdci_pkg::IDX_IIR0_LO_HI: rd_byte = thr0.low[15:8];
            pdci_pkg::IDX_IIR0_FMT: rd_byte = {7'h00, thr0.two_bit};
            pdci_pkg::IDX_IIR1_HI_LO: rd_byte = thr1.high[7:0];
            pdci_pkg::IDX_IIR1_HI_HI: rd_byte = thr1.high[15:8];
            pdci_pkg::IDX_IIR1_LO_LO: rd_byte = thr1.low[7:0];
            pdci_pkg::IDX_IIR1_LO_HI: rd_byte = thr1.low[15:8];
            pdci_pkg::IDX_IIR1_FMT: rd_byte = {7'h00, thr1.two_bit};
            pdci_pkg::IDX_HOLD_LO: rd_byte = hold_count[7:0];
            pdci_pkg::IDX_HOLD_HI: rd_byte = hold_count[15:8];
            pdci_pkg::IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status};
            pdci_pkg::IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask};
            pdci_pkg::IDX_FLAG_STATE: rd_byte = {2'h0, alarm1, alarm0, peak};
            default: begin
                rd_byte = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    // read channel, one read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= pdci_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h000000, rd_byte};
            rresp <= rd_ok ? pdci_pkg::RESP_OKAY : pdci_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    in_high_a: assert property (!input_sel |-> x0 == (high_hit ? 2'sb01 : 2'sb00))
        else $error("filter-0 input not from high pair");
    in_three_a: assert property (input_sel && !high_hit && !low_hit |-> x0 == 2'sb11)
        else $error("three-level input not minus one");
    in_plus_a: assert property (input_sel && high_hit |-> x0 == 2'sb01)
        else $error("three-level input not plus one");
    period_write_a: assert property (wr_en && wr_idx == pdci_pkg::IDX_PERIOD
        |=> exponent == $past(wdata_q[3:0]))
        else $error("period exponent not written");
    thr_byte_a: assert property (wr_en && wr_idx == pdci_pkg::IDX_IIR1_LO_HI
        |=> thr1.low[15:8] == $past(wdata_q) && $stable(thr1.low[7:0]))
        else $error("threshold high byte not written alone");
    irq_level_a: assert property (irq == |$past(next_status & irq_mask))
        else $error("interrupt level wrong");
    tick_space_a: assert property (tick |=> !tick [*7] ##1 tick)
        else $error("crossing tick spacing wrong");

    write_c: cover property (awvalid && awready ##[1:4] bvalid);
    three_level_c: cover property (input_sel && tick && x0 == 2'sb11);
    irq_c: cover property (!irq ##1 irq);
endmodule // pdci_top

/* test/pdci_agc_model.sv */
`timescale 1ns/1ps
// gain-control side: reads the alarm levels, never drives the detector
module pdci_agc_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // alarm levels from the detector
    input wire logic [1:0] alarm0,
    input wire logic [1:0] alarm1,
    input wire logic irq,
    // gain-control view
    output logic attenuate,
    output logic [7:0] irq_rises
);
    logic irq_q;

    // any raised alarm asks for less gain; irq edges are counted so lost or extra requests show
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            attenuate <= 1'b0;
            irq_q <= 1'b0;
            irq_rises <= 8'h00;
        end else begin
            attenuate <= |{alarm0, alarm1};
            irq_q <= irq;
            if (irq && !irq_q) begin
                irq_rises <= irq_rises + 8'h01;
            end
        end
    end
endmodule // pdci_agc_model

/* test/tb_power_detect_crossing_iir.sv */
`timescale 1ns/1ps
module tb_power_detect_crossing_iir;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    pdci_pkg::pdci_cmp_t cmp = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, attenuate;
    logic [1:0] bresp, rresp, alarm0, alarm1;
    logic [31:0] rdata, rd;
    logic [7:0] irq_rises;
    logic [3:0] alarms;
    logic [1:0] rsp;
    logic ok;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;

    assign alarms = {alarm1, alarm0};

    // 20 MHz clock
    always #25 aclk = ~aclk;

    pdci_top i_dut (
        .aclk(aclk), .aresetn(aresetn), .cmp(cmp),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'h1),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .alarm0(alarm0), .alarm1(alarm1), .irq(irq)
    );

    pdci_agc_model i_agc (
        .aclk(aclk), .aresetn(aresetn), .alarm0(alarm0), .alarm1(alarm1), .irq(irq),
        .attenuate(attenuate), .irq_rises(irq_rises)
    );

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // a hang is cut short well past the longest sequence
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic check_data(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi, input string what);
        cmp_count++;
        if (got < lo || got > hi) begin
            errors++;
            $display("CHECK FAILED at %0t: %s took %0d cycles", $time, what, got);
        end
    endtask

    // one write; both channels offered together, each dropped once taken
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
        int k;
        k = 0;
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 100);
        bready <= 1'b0;
        check_data({31'h0, bvalid}, 32'h1, "write answered");
        check_data({30'h0, bresp}, {30'h0, er}, "write response");
        @(posedge aclk);
    endtask

    task automatic w(input logic [5:0] idx, input logic [7:0] d);
        wr(idx, d, pdci_pkg::RESP_OKAY);
    endtask

    // one read; an extra edge afterwards keeps ready from being set twice in a step
    task automatic rdreg(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
        int k;
        k = 0;
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 100);
        rready <= 1'b0;
        check_data({31'h0, rvalid}, 32'h1, "read answered");
        d = rdata;
        r = rresp;
        @(posedge aclk);
    endtask

    task automatic wait_bit(input int i, input logic v, output int k);
        k = 0;
        while (alarms[i] !== v && k < 200) begin
            @(posedge aclk);
            k++;
        end
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge aclk);
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        settle(2);
        for (int i = 13; i <= 42; i++) begin
            ok = i inside {[13:19], [22:26], 29, 30, [40:42]};
            rdreg(6'(i), rd, rsp);
            check_data({30'h0, rsp}, {30'h0, ok ? pdci_pkg::RESP_OKAY : pdci_pkg::RESP_SLVERR}, "read resp");
            if (ok) check_data(rd, 32'h0, "reset value");
        end
        wr(6'h02, 8'h00, pdci_pkg::RESP_SLVERR);
        $display("test reset finished");
        w(6'h0e, 8'h0f);
        rdreg(6'h0e, rd, rsp);
        check_data(rd, 32'h0f, "period exponent");
        w(6'h0e, 8'h00);
        w(6'h10, 8'h30);
        w(6'h12, 8'h10);
        w(6'h17, 8'h20);
        w(6'h19, 8'h08);
        rdreg(6'h10, rd, rsp);
        check_data(rd, 32'h30, "threshold byte");
        $display("test registers finished");
        cmp <= 4'b0011;
        settle(24);
        check_data(alarms, 4'h0, "low pair ignored");
        cmp <= 4'b0100;
        wait_bit(0, 1'b1, n);
        // one tick to load y, one tick to compare, two register stages, one edge to see it
        check_range(n, 12, 19, "peak set");
        rdreg(6'h28, rd, rsp);
        check_data(rd, 32'h03, "status");
        check_data(irq, 1'b0, "irq masked");
        w(6'h29, 8'h01);
        settle(2);
        check_data(irq, 1'b1, "irq unmasked");
        w(6'h28, 8'h03);
        settle(2);
        check_data(irq, 1'b0, "irq cleared");
        rdreg(6'h28, rd, rsp);
        check_data(rd, 32'h00, "status cleared");
        w(6'h29, 8'h00);
        $display("test peak and irq finished");
        w(6'h13, 8'h01);
        settle(3);
        check_data(alarms, 4'b0110, "two-bit format");
        rdreg(6'h2a, rd, rsp);
        check_data(rd, 32'h1b, "flag state");
        w(6'h1d, 8'h02);
        cmp <= 4'h0;
        wait_bit(1, 1'b0, n);
        // first tick still compares the old high output, then three ticks below low with hold 2
        check_range(n, 28, 35, "peak hold run");
        settle(3);
        check_data(alarm0, 2'b01, "below low");
        $display("test format and hold finished");
        w(6'h12, 8'he0);
        settle(24);
        check_data(alarm0, 2'b00, "select 0 idle");
        w(6'h0d, 8'h01);
        settle(24);
        check_data(alarm0, 2'b01, "minus one");
        cmp <= 4'b0011;
        settle(24);
        check_data(alarm0, 2'b00, "zero level");
        cmp <= 4'b1000;
        settle(24);
        check_data(alarm0, 2'b10, "plus one");
        check_data(irq, 1'b0, "mask holds irq");
        $display("test three level finished");
        w(6'h0d, 8'h00);
        cmp <= 4'h0;
        settle(48);
        check_data(alarm1, 2'b00, "filter 1 idle");
        w(6'h0e, 8'h02);
        cmp <= 4'b1000;
        wait_bit(2, 1'b1, n);
        // exponent 2 passes 2000h only on the third step, so the flag sets at the fourth tick
        check_range(n, 28, 35, "slow filter");
        check_data(irq_rises, 8'h01, "irq requests seen");
        w(6'h1a, 8'h01);
        settle(2);
        check_data(alarm1, 2'b10, "filter 1 two-bit");
        check_data(attenuate, 1'b1, "gain request");
        $display("test period finished");
        close_out();
    end
endmodule // tb_power_detect_crossing_iir
